// File: rtl/apc_pkg.sv
package apc_pkg;
  // master clock and wake timing
  localparam int unsigned MCLK_HZ = 250_000_000;
  localparam int unsigned WAKE_EXT_PER = 2; // master clock periods
  localparam int unsigned WAKE_EXT_CYC = WAKE_EXT_PER;
  localparam int unsigned WAKE_POR_CYC = 262144; // 2^18 periods
  localparam int unsigned WCNT_W = 19;

  // first configuration register
  localparam logic [7:0] CFG0_RST = 8'h0A;
  localparam int unsigned CFG0_CLKOUT_EN_BIT = 1;

  // status byte layout
  localparam int unsigned ST_NEW_BIT = 7;
  localparam int unsigned ST_OVF_BIT = 6;
  localparam int unsigned ST_SUPPLY_BIT = 5;
  localparam int unsigned CHAN_W = 5;
  localparam logic [4:0] CH_SUPPLY = 5'h1A;

  // supply monitor in millivolts
  localparam logic [12:0] SUP_TRIP_MV = 13'h10CC; // 4300
  localparam logic [12:0] SUP_HYST_MV = 13'h0032; // 50

  // output code scaling: raw full scale 2^24 maps to 780000h
  localparam int unsigned RAW_W = 26;
  localparam logic [4:0] SCALE_MUL = 5'h0F;
  localparam int unsigned SCALE_SHIFT = 5;
  localparam logic [23:0] CODE_POS_FS = 24'h780000;
  localparam logic [23:0] CODE_NEG_FS = 24'h87FFFF;
  localparam logic [23:0] CODE_CLIP_POS = 24'h7FFFFF;
  localparam logic [23:0] CODE_CLIP_NEG = 24'h800000;

  // synchroniser lanes
  localparam int unsigned SY_PWD = 0;
  localparam int unsigned SY_PRST = 1;
  localparam int unsigned SY_SEL = 2;
  localparam int unsigned SY_START = 3;
  localparam int unsigned SY_CS = 4;
  localparam int unsigned SY_STARTED = 5;
  localparam int unsigned SY_EXTCLK = 6;
  localparam int unsigned SY_W = 7;
  localparam logic [6:0] SY_RST = 7'h33;

  typedef enum logic [1:0] {
    APC_DOWN, APC_WAKE, APC_IDLE, APC_CONV
  } apc_mode_type;

  typedef struct packed {
    logic [7:0] status;
    logic [23:0] data;
  } apc_res_type;

  typedef struct packed {
    logic [SY_W-1:0] s1;
    logic [SY_W-1:0] s2;
  } apc_sync_type;

  typedef struct packed {
    logic started;
    logic [31:0] shreg;
  } apc_link_type;

  typedef struct packed {
    apc_mode_type mode;
    logic [WCNT_W-1:0] wake_cnt;
    logic por_wait;
    logic pwd_prev;
    logic prst_prev;
    logic sel_prev;
    logic ext_prev;
    logic ext_seen;
    logic rd_prev;
    logic [7:0] cfg0;
    logic result_ready_n_n;
    logic result_ready_n_relow;
    logic supply_low;
    apc_res_type word;
    apc_res_type pend;
    logic pend_v;
    logic clk_div;
    logic filt_clr;
  } apc_main_type;
endpackage : apc_pkg

// File: rtl/apc_top.sv
`timescale 1ns/1ps

// two-flop synchroniser bank
module apc_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [apc_pkg::SY_W-1:0] i_d,
  output logic [apc_pkg::SY_W-1:0] o_q
);
  apc_pkg::apc_sync_type st_ff;
  apc_pkg::apc_sync_type nxt_st;

  // first stage feeds only the second
  always_comb begin
    nxt_st.s1 = i_d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= {apc_pkg::SY_RST, apc_pkg::SY_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_q = st_ff.s2;
endmodule : apc_sync

// serial read side, on the host serial clock
module apc_link (
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire apc_pkg::apc_res_type i_word,
  output logic o_started,
  output logic o_dout
);
  apc_pkg::apc_link_type st_ff;
  apc_pkg::apc_link_type nxt_st;

  // first falling edge loads the word, later ones shift
  always_comb begin
    nxt_st = st_ff;
    nxt_st.started = 1'b1;
    if (!st_ff.started) begin
      nxt_st.shreg = i_word;
    end else begin
      nxt_st.shreg = {st_ff.shreg[30:0], 1'b0};
    end
  end

  // the frame select ends the frame, no idle clock needed
  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_started = st_ff.started;
  assign o_dout = st_ff.shreg[31];
endmodule : apc_link

module apc_top #(
  parameter int unsigned POR_CYC = apc_pkg::WAKE_POR_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_power_down_n,
  input wire logic i_pin_reset_n,
  input wire logic i_clock_source_select,
  input wire logic i_start,
  input wire logic i_osc_ready,
  input wire logic i_bidir_clock_pin_i,
  output logic o_bidir_clock_pin_o,
  output logic o_bidir_clock_pin_oe_n,
  input wire logic i_cfg0_wr,
  input wire logic [7:0] i_cfg0_data,
  output logic [7:0] o_first_config_register,
  input wire logic i_conv_valid,
  input wire logic signed [apc_pkg::RAW_W-1:0] i_conv_raw,
  input wire logic [apc_pkg::CHAN_W-1:0] i_conv_chan,
  input wire logic [12:0] i_supply_mv,
  output logic o_conv_run,
  output logic o_filter_clear,
  output logic o_power_down,
  output logic o_osc_enable,
  output logic o_wake_done,
  output logic o_result_ready_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  output logic o_dout
);
  localparam logic [apc_pkg::WCNT_W-1:0] POR_LAST =
    apc_pkg::WCNT_W'(POR_CYC - 1);
  localparam logic [apc_pkg::WCNT_W-1:0] EXT_LAST =
    apc_pkg::WCNT_W'(apc_pkg::WAKE_EXT_CYC - 1);
  localparam logic [12:0] SUP_CLEAR_MV =
    apc_pkg::SUP_TRIP_MV + apc_pkg::SUP_HYST_MV;
  localparam int RAW_BITS = 32; // width of the scaling product

  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [apc_pkg::SY_W-1:0] sy_in;
  logic [apc_pkg::SY_W-1:0] sy;
  logic started;
  apc_pkg::apc_main_type st_ff;
  apc_pkg::apc_main_type nxt_st;

  // reset release through two flops
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // pins and link level into the master domain
  always_comb begin
    sy_in = '0;
    sy_in[apc_pkg::SY_PWD] = i_power_down_n;
    sy_in[apc_pkg::SY_PRST] = i_pin_reset_n;
    sy_in[apc_pkg::SY_SEL] = i_clock_source_select;
    sy_in[apc_pkg::SY_START] = i_start;
    sy_in[apc_pkg::SY_CS] = i_cs_n;
    sy_in[apc_pkg::SY_STARTED] = started;
    sy_in[apc_pkg::SY_EXTCLK] = i_bidir_clock_pin_i;
  end

  apc_sync u_sync (
    .i_clk(i_mclk),
    .i_rst_n(rst_n),
    .i_d(sy_in),
    .o_q(sy)
  );

  apc_link u_link (
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_word(st_ff.word),
    .o_started(started),
    .o_dout(o_dout)
  );

  // main control: power, wake, start, results
  always_comb begin
    logic pd_low;
    logic prst_low;
    logic sel_ext;
    logic frame;
    logic rd_edge;
    logic run;
    logic conv;
    logic go;
    logic [23:0] code;
    logic ovf;
    logic signed [RAW_BITS-1:0] prod;
    apc_pkg::apc_res_type res;
    pd_low = 1'b0;
    prst_low = 1'b0;
    sel_ext = 1'b0;
    frame = 1'b0;
    rd_edge = 1'b0;
    run = 1'b0;
    conv = 1'b0;
    go = 1'b0;
    code = '0;
    ovf = 1'b0;
    prod = '0;
    res = '0;
    nxt_st = st_ff;
    pd_low = !sy[apc_pkg::SY_PWD] && !st_ff.pwd_prev;
    prst_low = !sy[apc_pkg::SY_PRST] && !st_ff.prst_prev;
    nxt_st.pwd_prev = sy[apc_pkg::SY_PWD];
    nxt_st.prst_prev = sy[apc_pkg::SY_PRST];
    sel_ext = sy[apc_pkg::SY_SEL];
    nxt_st.sel_prev = sel_ext;
    nxt_st.ext_prev = sy[apc_pkg::SY_EXTCLK];
    frame = !sy[apc_pkg::SY_CS] || sy[apc_pkg::SY_STARTED];
    rd_edge = sy[apc_pkg::SY_STARTED] && !st_ff.rd_prev;
    nxt_st.rd_prev = sy[apc_pkg::SY_STARTED];
    run = (st_ff.mode == apc_pkg::APC_CONV);
    conv = i_conv_valid && run;

    if (i_supply_mv < apc_pkg::SUP_TRIP_MV) begin
      nxt_st.supply_low = 1'b1;
    end else if (i_supply_mv >= SUP_CLEAR_MV) begin
      nxt_st.supply_low = 1'b0;
    end

    // scale raw value to output code
    prod = RAW_BITS'(i_conv_raw) *
      RAW_BITS'(signed'({1'b0, apc_pkg::SCALE_MUL}));
    prod = prod >>> apc_pkg::SCALE_SHIFT;
    code = prod[23:0];
    if (prod > RAW_BITS'(signed'({8'h00, apc_pkg::CODE_CLIP_POS}))) begin
      code = apc_pkg::CODE_CLIP_POS;
      ovf = 1'b1;
    end else if (prod <
        -RAW_BITS'(signed'({8'h00, apc_pkg::CODE_CLIP_NEG}))) begin
      code = apc_pkg::CODE_CLIP_NEG;
      ovf = 1'b1;
    end
    if (i_conv_chan == apc_pkg::CH_SUPPLY && st_ff.supply_low) begin
      code = '0;
    end
    res.data = code;
    res.status[apc_pkg::ST_NEW_BIT] = 1'b1;
    res.status[apc_pkg::ST_OVF_BIT] = ovf;
    res.status[apc_pkg::ST_SUPPLY_BIT] = st_ff.supply_low;
    res.status[apc_pkg::CHAN_W-1:0] = i_conv_chan;

    // read clears flag, new result wins
    if (rd_edge) begin
      nxt_st.word.status[apc_pkg::ST_NEW_BIT] = 1'b0;
    end
    // a result during a frame waits in pend, not in word
    if (conv && frame) begin
      nxt_st.pend = res;
      nxt_st.pend_v = 1'b1;
    end else if (conv) begin
      nxt_st.word = res;
      nxt_st.pend_v = 1'b0;
    end else if (!frame && st_ff.pend_v) begin
      nxt_st.word = st_ff.pend;
      nxt_st.pend_v = 1'b0;
    end

    if (conv) begin
      nxt_st.result_ready_n_n = 1'b1;
      nxt_st.result_ready_n_relow = 1'b1;
    end else if (st_ff.result_ready_n_relow) begin
      nxt_st.result_ready_n_n = 1'b0;
      nxt_st.result_ready_n_relow = 1'b0;
    end else if (rd_edge) begin
      nxt_st.result_ready_n_n = 1'b1;
    end

    // configuration write, ignored when powered down
    if (i_cfg0_wr && st_ff.mode != apc_pkg::APC_DOWN) begin
      nxt_st.cfg0 = i_cfg0_data;
    end

    // external clock activity marks a valid clock
    if (sy[apc_pkg::SY_EXTCLK] != st_ff.ext_prev) begin
      nxt_st.ext_seen = 1'b1;
    end

    nxt_st.filt_clr = 1'b0;
    nxt_st.clk_div = !st_ff.clk_div;

    if (prst_low) begin
      nxt_st.mode = apc_pkg::APC_IDLE;
      nxt_st.cfg0 = apc_pkg::CFG0_RST;
      nxt_st.word = '0;
      nxt_st.pend = '0;
      nxt_st.pend_v = 1'b0;
      nxt_st.result_ready_n_n = 1'b1;
      nxt_st.result_ready_n_relow = 1'b0;
      nxt_st.filt_clr = 1'b1;
      nxt_st.por_wait = 1'b0;
      nxt_st.wake_cnt = '0;
    end else if (pd_low) begin
      nxt_st.mode = apc_pkg::APC_DOWN;
      nxt_st.clk_div = 1'b0;
    end else if (sel_ext != st_ff.sel_prev &&
        st_ff.mode != apc_pkg::APC_DOWN) begin
      nxt_st.mode = apc_pkg::APC_WAKE;
      nxt_st.wake_cnt = '0;
      nxt_st.ext_seen = 1'b0;
    end else begin
      unique case (st_ff.mode)
        apc_pkg::APC_DOWN: begin
          nxt_st.mode = apc_pkg::APC_WAKE;
          nxt_st.wake_cnt = '0;
          nxt_st.ext_seen = 1'b0;
          nxt_st.clk_div = 1'b0;
        end
        apc_pkg::APC_WAKE: begin
          go = sel_ext ? st_ff.ext_seen : i_osc_ready;
          if (go) begin
            nxt_st.wake_cnt = st_ff.wake_cnt + 1'b1;
            if (st_ff.por_wait) begin
              if (st_ff.wake_cnt == POR_LAST) begin
                nxt_st.mode = apc_pkg::APC_IDLE;
                nxt_st.por_wait = 1'b0;
              end
            end else if (!sel_ext || st_ff.wake_cnt == EXT_LAST) begin
              nxt_st.mode = apc_pkg::APC_IDLE;
            end
          end
        end
        apc_pkg::APC_IDLE: begin
          if (sy[apc_pkg::SY_START]) begin
            nxt_st.mode = apc_pkg::APC_CONV;
          end
        end
        apc_pkg::APC_CONV: begin
          if (i_conv_valid && !sy[apc_pkg::SY_START]) begin
            nxt_st.mode = apc_pkg::APC_IDLE;
          end
        end
      endcase
    end
  end

  // power-on reset loads the reset pin defaults, then waits out the wake count
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{mode: apc_pkg::APC_WAKE, wake_cnt: '0,
        por_wait: 1'b1, pwd_prev: 1'b1, prst_prev: 1'b1,
        sel_prev: 1'b0, ext_prev: 1'b0, ext_seen: 1'b0,
        rd_prev: 1'b1, cfg0: apc_pkg::CFG0_RST, result_ready_n_n: 1'b1,
        result_ready_n_relow: 1'b0, supply_low: 1'b0, word: '0,
        pend: '0, pend_v: 1'b0, clk_div: 1'b0,
        filt_clr: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // output drive
  assign o_conv_run = (st_ff.mode == apc_pkg::APC_CONV);
  assign o_filter_clear = st_ff.filt_clr;
  assign o_power_down = (st_ff.mode == apc_pkg::APC_DOWN);
  assign o_osc_enable = (st_ff.mode != apc_pkg::APC_DOWN);
  assign o_wake_done = (st_ff.mode == apc_pkg::APC_IDLE) ||
    (st_ff.mode == apc_pkg::APC_CONV);
  assign o_result_ready_n = st_ff.result_ready_n_n;
  assign o_first_config_register = st_ff.cfg0;
  assign o_bidir_clock_pin_o = st_ff.clk_div;
  // clock out only on crystal with enable set
  assign o_bidir_clock_pin_oe_n = !(o_wake_done && !st_ff.sel_prev &&
    st_ff.cfg0[apc_pkg::CFG0_CLKOUT_EN_BIT]);
endmodule : apc_top

// File: test/apc_properties.sv
`timescale 1ns/1ps
// port-level timing checks on the converter control block
module apc_properties (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_power_down_n,
  input wire logic i_pin_reset_n,
  input wire logic i_clock_source_select,
  input wire logic i_start,
  input wire logic i_cs_n,
  input wire logic i_conv_valid,
  input wire logic o_bidir_clock_pin_oe_n,
  input wire logic [7:0] o_first_config_register,
  input wire logic o_conv_run,
  input wire logic o_power_down,
  input wire logic o_osc_enable,
  input wire logic o_wake_done,
  input wire logic o_result_ready_n
);
  logic [2:0] age_ff;

  // cycles since reset release, saturating; masks the release edges
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      age_ff <= 3'h0;
    end else if (age_ff != 3'h7) begin
      age_ff <= age_ff + 3'h1;
    end
  end

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n || age_ff != 3'h7);

  property p_pd_on;
    !i_power_down_n [*8] |-> o_power_down && !o_osc_enable;
  endproperty
  a_pd_on: assert property (p_pd_on)
    else $error("power down not engaged");
  property p_cfg_keep;
    i_pin_reset_n [*6] ##0 o_power_down |=> $stable(o_first_config_register);
  endproperty
  a_cfg_keep: assert property (p_cfg_keep)
    else $error("config changed in power down");
  // clock pin driven only when enabled and awake
  property p_clk_out;
    !o_bidir_clock_pin_oe_n |-> o_wake_done && o_first_config_register[1];
  endproperty
  a_clk_out: assert property (p_clk_out)
    else $error("clock pin driven wrongly");
  property p_ext_sel;
    i_clock_source_select [*5] |-> o_bidir_clock_pin_oe_n;
  endproperty
  a_ext_sel: assert property (p_ext_sel)
    else $error("pin driven with external clock");
  // ready pulses high then low on a result
  property p_rdy_pulse;
    i_cs_n [*4] ##0 (o_conv_run && i_conv_valid)
      |=> o_result_ready_n ##1 !o_result_ready_n;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("ready pulse wrong");
  // start low stops after the running result
  property p_stop;
    !i_start [*5] ##0 (o_conv_run && i_conv_valid) |=> !o_conv_run;
  endproperty
  a_stop: assert property (p_stop)
    else $error("conversion did not stop");
  // converting continues until a result or a power down ends it
  property p_run_hold;
    i_pin_reset_n [*6] ##0 (o_conv_run && !i_conv_valid)
      |=> o_conv_run || o_power_down;
  endproperty
  a_run_hold: assert property (p_run_hold)
    else $error("conversion dropped early");
  property p_prst;
    !i_pin_reset_n [*8] |-> o_first_config_register == 8'h0A
      && o_result_ready_n;
  endproperty
  a_prst: assert property (p_prst)
    else $error("reset pin defaults missing");
endmodule : apc_properties

// File: test/apc_host.sv
`timescale 1ns/1ps
// host serial reader; its clock runs only inside a frame
module apc_host (
  input wire logic i_dout,
  output logic o_sclk,
  output logic o_cs_n,
  output logic [31:0] o_word,
  output logic o_done
);
  // idle levels
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_word = 32'h0;
    o_done = 1'b0;
  end

  // one read frame, msb first, status byte leading
  task automatic read_frame();
    int i;
    o_cs_n = 1'b0;
    #23;
    for (i = 0; i < 32; i++) begin
      o_sclk = 1'b1;
      #15;
      o_sclk = 1'b0;
      #15;
      o_word[31-i] = i_dout;
    end
    o_cs_n = 1'b1;
    o_done = 1'b1;
    #20;
    o_done = 1'b0;
    #20;
  endtask : read_frame
endmodule : apc_host

// File: test/tb_adc_pin_control_and_readout.sv
`timescale 1ns/1ps
module tb_adc_pin_control_and_readout;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_power_down_n = 1'b1;
  logic i_pin_reset_n = 1'b1;
  logic i_clock_source_select = 1'b0;
  logic i_start = 1'b0;
  logic i_osc_ready = 1'b1;
  logic ext_clk = 1'b0;
  logic i_cfg0_wr = 1'b0;
  logic [7:0] i_cfg0_data = 8'h00;
  logic i_conv_valid = 1'b0;
  logic signed [25:0] i_conv_raw = 26'h0;
  logic [4:0] i_conv_chan = 5'h00;
  logic [12:0] i_supply_mv = 13'h1388;
  wire logic i_bidir_clock_pin_i, clk_o, o_bidir_clock_pin_oe_n;
  wire logic o_conv_run, o_power_down, o_osc_enable, o_filter_clear;
  wire logic o_wake_done, o_result_ready_n, i_sclk, i_cs_n, o_dout;
  wire logic host_done;
  wire logic [7:0] o_first_config_register;
  wire logic [31:0] host_word;
  logic signed [25:0] tv[4] = '{26'sh0, 26'sh1000000, 26'sh1FFFFFF,
    26'sh2000000};
  logic [12:0] mv[3] = '{13'h10CB, 13'h10E0, 13'h10FE};
  logic [31:0] exp_q[$];
  int n_fail = 0;
  int checked = 0;

  apc_top #(.POR_CYC(16)) apc_top_i (
    .i_mclk, .i_rst_n, .i_power_down_n, .i_pin_reset_n,
    .i_clock_source_select, .i_start, .i_osc_ready, .i_bidir_clock_pin_i,
    .o_bidir_clock_pin_o(clk_o), .o_bidir_clock_pin_oe_n, .i_cfg0_wr,
    .i_cfg0_data, .o_first_config_register, .i_conv_valid, .i_conv_raw,
    .i_conv_chan, .i_supply_mv, .o_conv_run, .o_filter_clear,
    .o_power_down, .o_osc_enable, .o_wake_done, .o_result_ready_n,
    .i_sclk, .i_cs_n, .o_dout
  );
  apc_host apc_host_i (
    .i_dout(o_dout), .o_sclk(i_sclk), .o_cs_n(i_cs_n),
    .o_word(host_word), .o_done(host_done)
  );

  // clocks; the pin carries whichever party drives it
  always #2 i_mclk = ~i_mclk;
  always @(negedge i_mclk) ext_clk <= ~ext_clk;
  assign i_bidir_clock_pin_i = o_bidir_clock_pin_oe_n ? ext_clk : clk_o;

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic cyc(int n);
    repeat (n) @(negedge i_mclk);
  endtask : cyc

  task automatic wait_wake();
    int k;
    for (k = 0; k < 100 && o_wake_done !== 1'b1; k++) cyc(1);
    chk("wake done", 1'b1, o_wake_done);
  endtask : wait_wake

  task automatic wcfg(logic [7:0] d);
    i_cfg0_data = d;
    i_cfg0_wr = 1'b1;
    cyc(1);
    i_cfg0_wr = 1'b0;
    cyc(3);
  endtask : wcfg

  // one filter result; ready must be low afterwards
  task automatic put(logic signed [25:0] r, logic [4:0] c);
    i_conv_raw = r;
    i_conv_chan = c;
    i_conv_valid = 1'b1;
    cyc(1);
    i_conv_valid = 1'b0;
    cyc(1);
    chk("ready low", 1'b0, o_result_ready_n);
  endtask : put

  // note the expected word, read it, ready must be released
  task automatic rd(logic [31:0] e);
    exp_q.push_back(e);
    apc_host_i.read_frame();
    cyc(1);
    chk("ready after read", 1'b1, o_result_ready_n);
  endtask : rd

  // status and code expected from a fresh result
  function automatic logic [31:0] exp_word(logic signed [25:0] r,
      logic [4:0] c, logic lo);
    logic signed [31:0] p;
    p = (32'(r) * 32'sh0F) >>> 5;
    if (c == apc_pkg::CH_SUPPLY && lo) p = 32'sh0;
    if (p > 32'sh7FFFFF) return {2'b11, lo, c, 24'h7FFFFF};
    if (p < -32'sh800000) return {2'b11, lo, c, 24'h800000};
    return {2'b10, lo, c, p[23:0]};
  endfunction : exp_word

  // compare each finished read with the oldest note
  always @(posedge host_done) begin
    if (exp_q.size() == 0) begin
      chk("unexpected read", 32'h0, 32'hFFFFFFFF);
    end else begin
      chk("read word", exp_q.pop_front(), host_word);
    end
  end

  // watchdog
  initial begin
    #100000;
    n_fail++;
    report_and_stop();
  end

  // main sequence
  initial begin
    int i;
    logic signed [25:0] r;
    logic [4:0] c;
    logic b;
    void'($urandom(36731));
    cyc(20);
    i_rst_n = 1'b1;
    cyc(10);
    chk("wake early", 1'b0, o_wake_done);
    wait_wake();
    chk("cfg reset", 8'h0A, o_first_config_register);
    chk("clk out", 1'b0, o_bidir_clock_pin_oe_n);
    b = clk_o;
    cyc(1);
    chk("clk toggle", !b, clk_o);
    i_clock_source_select = 1'b1;
    cyc(12);
    chk("ext release", 1'b1, o_bidir_clock_pin_oe_n);
    chk("ext wake", 1'b1, o_wake_done);
    i_clock_source_select = 1'b0;
    cyc(4);
    wait_wake();
    wcfg(8'h08);
    chk("clk off", 1'b1, o_bidir_clock_pin_oe_n);
    i_power_down_n = 1'b0;
    i_osc_ready = 1'b0;
    cyc(10);
    chk("pd", 1'b1, o_power_down);
    chk("osc", 1'b0, o_osc_enable);
    wcfg(8'h0A);
    chk("cfg pd", 8'h08, o_first_config_register);
    i_power_down_n = 1'b1;
    cyc(8);
    chk("osc wait", 1'b0, o_wake_done);
    i_osc_ready = 1'b1;
    wait_wake();
    chk("cfg kept", 8'h08, o_first_config_register);
    i_start = 1'b1;
    cyc(6);
    chk("run", 1'b1, o_conv_run);
    for (i = 0; i < 12; i++) begin
      r = (i < 4) ? tv[i] : 26'($urandom);
      c = 5'($urandom_range(15, 0));
      put(r, c);
      rd(exp_word(r, c, 1'b0));
    end
    chk("loop run", 1'b1, o_conv_run);
    put(26'sh100, 5'h01);
    put(26'sh200, 5'h02);
    rd(exp_word(26'sh200, 5'h02, 1'b0));
    rd(exp_word(26'sh200, 5'h02, 1'b0) & 32'h7FFFFFFF);
    for (i = 0; i < 3; i++) begin
      i_supply_mv = mv[i];
      cyc(4);
      put(26'sh10000, apc_pkg::CH_SUPPLY);
      rd(exp_word(26'sh10000, apc_pkg::CH_SUPPLY, i < 2));
    end
    // model holds no chopping, system readings direct
    put(26'sh800000, apc_pkg::CH_SUPPLY);
    rd(exp_word(26'sh800000, apc_pkg::CH_SUPPLY, 1'b0));
    chk("supply volts", 32'h5, 32'(host_word[23:0] / 786432));
    put(26'sh1000000, 5'h00);
    rd(exp_word(26'sh1000000, 5'h00, 1'b0));
    chk("gain ratio", 32'h1, 32'(host_word[23:0] / 7864320));
    i_start = 1'b0;
    cyc(6);
    chk("finish conv", 1'b1, o_conv_run);
    put(26'sh300, 5'h04);
    chk("idle", 1'b0, o_conv_run);
    rd(exp_word(26'sh300, 5'h04, 1'b0));
    i_start = 1'b1;
    cyc(6);
    put(26'sh400, 5'h05);
    i_pin_reset_n = 1'b0;
    for (i = 0; i < 10 && o_filter_clear !== 1'b1; i++) cyc(1);
    chk("filter clr", 1'b1, o_filter_clear);
    cyc(8);
    chk("cfg dflt", 8'h0A, o_first_config_register);
    chk("rdy dflt", 1'b1, o_result_ready_n);
    i_pin_reset_n = 1'b1;
    cyc(10);
    chk("run again", 1'b1, o_conv_run);
    report_and_stop();
  end
endmodule : tb_adc_pin_control_and_readout

bind apc_top apc_properties apc_properties_i (
  .i_mclk, .i_rst_n, .i_power_down_n, .i_pin_reset_n,
  .i_clock_source_select, .i_start, .i_cs_n, .i_conv_valid,
  .o_bidir_clock_pin_oe_n, .o_first_config_register, .o_conv_run,
  .o_power_down, .o_osc_enable, .o_wake_done, .o_result_ready_n
);
